// [rtl/eprd_pkg.sv]
// constants and register map of the external pin request detector
//
// Overview of operation
// R1: control bit 7 reads zero, ignores writes
// R2: pull disable bit acts only while enabled
// R3: polarity bit picks falling/low or rising/high
// R4: rising polarity forces the pullup off
// R5: pin enable gates every request event
// R6: event flag is read only, set by hardware
// R7: writing one to acknowledge clears the flag
// R8: edge-and-level mode holds flag while pin asserted
// R9: interrupt enable drives request from event flag
// R10: mode bit picks edge only or edge+level
// R11: edge is de-asserted to asserted transition
// R12: turning pin function on sets the flag
// R13: pin synchronised in two stages, reset one; control registers reset zero
package eprd_pkg;

	// ****************************************************************
	// register indices and byte addresses
	// ****************************************************************
	localparam logic [7:0] CTRL_IDX  = 8'h3B;
	localparam logic [7:0] STAT_IDX  = 8'h3C;
	localparam logic [7:0] MASK_IDX  = 8'h3D;
	localparam logic [7:0] CTRL_ADDR = {CTRL_IDX[5:0], 2'b00};
	localparam logic [7:0] STAT_ADDR = {STAT_IDX[5:0], 2'b00};
	localparam logic [7:0] MASK_ADDR = {MASK_IDX[5:0], 2'b00};

	// ****************************************************************
	// control register fields
	// ****************************************************************
	localparam int BIT_RSVD = 7;
	localparam int BIT_PDD  = 6;
	localparam int BIT_EDG  = 5;
	localparam int BIT_PE   = 4;
	localparam int BIT_FLAG = 3;
	localparam int BIT_ACK  = 2;
	localparam int BIT_IE   = 1;
	localparam int BIT_MOD  = 0;
	localparam logic [7:0] CTRL_RST = 8'h00;

	// ****************************************************************
	// sticky status and mask fields
	// ****************************************************************
	localparam int ST_W       = 2;
	localparam int ST_EVENT   = 0;
	localparam int ST_REFUSED = 1;
	localparam logic [ST_W-1:0] STAT_RST = 2'h0;
	localparam logic [ST_W-1:0] MASK_RST = 2'h0;

	// ****************************************************************
	// bus answers
	// ****************************************************************
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [rtl/eprd_sync.sv]
// two-flop synchroniser with a constant reset value
module eprd_sync
	import eprd_pkg::*;
#(
	parameter logic RST_VAL = 1'b0
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// data
	input  wire logic d_i,
	output logic      q_o
);

	logic meta;
	logic next_meta;
	logic next_q;

	always_comb begin
		next_meta = d_i;
		next_q    = meta;
	end

	// the first stage feeds only the second
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta <= RST_VAL;
			q_o  <= RST_VAL;
		end else begin
			meta <= next_meta;
			q_o  <= next_q;
		end
	end

	a_sync_two_stage: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R13
		($past(rst_n_i, 2) && $past(rst_n_i)) |-> (q_o == $past(d_i, 2)))
		else $error("synchroniser output is not input delayed by two");

endmodule

// [rtl/eprd_detect.sv]
// polarity-aware edge and level detector for the synchronised pin
module eprd_detect
	import eprd_pkg::*;
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// pin and configuration
	input  wire logic pin_i,
	input  wire logic rising_i,
	input  wire logic enable_i,
	// detection results
	output logic      asserted_o,
	output logic      edge_o
);

	logic prev_asserted;
	logic next_prev_asserted;

	always_comb begin
		asserted_o         = rising_i ? pin_i : ~pin_i; // see R3
		edge_o             = enable_i & asserted_o & ~prev_asserted; // see R11
		next_prev_asserted = asserted_o;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prev_asserted <= 1'b0;
		end else begin
			prev_asserted <= next_prev_asserted;
		end
	end

	a_polarity_level: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R3
		asserted_o == (rising_i ? pin_i : !pin_i))
		else $error("asserted level does not follow polarity");

	a_edge_needs_change: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see R11
		edge_o |-> ($past(asserted_o) == 1'b0) && enable_i)
		else $error("edge reported without a transition");

endmodule

// [rtl/eprd_top.sv]
// external pin request detector with its axi4-lite register slave
module eprd_top
	import eprd_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input  wire logic              CLK_I,
	input  wire logic              RST_N_I,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
	input  wire logic              S_AXI_AWVALID_I,
	output logic                   S_AXI_AWREADY_O,
	// axi4-lite write data
	input  wire logic [31:0]       S_AXI_WDATA_I,
	input  wire logic [3:0]        S_AXI_WSTRB_I,
	input  wire logic              S_AXI_WVALID_I,
	output logic                   S_AXI_WREADY_O,
	// axi4-lite write response
	output logic [1:0]             S_AXI_BRESP_O,
	output logic                   S_AXI_BVALID_O,
	input  wire logic              S_AXI_BREADY_I,
	// axi4-lite read address
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
	input  wire logic              S_AXI_ARVALID_I,
	output logic                   S_AXI_ARREADY_O,
	// axi4-lite read data
	output logic [31:0]            S_AXI_RDATA_O,
	output logic [1:0]             S_AXI_RRESP_O,
	output logic                   S_AXI_RVALID_O,
	input  wire logic              S_AXI_RREADY_I,
	// request pin and its pull device
	input  wire logic              REQ_PIN_I,
	output logic                   PULL_EN_O,
	// requests to the cpu
	output logic                   CPU_REQ_O,
	output logic                   INT_O
);

	// ****************************************************************
	// elaboration check
	// ****************************************************************
	if (ADDR_W < 8) begin : g_bad_addr
		$error("ADDR_W must be at least 8");
	end

	// ****************************************************************
	// reset release and pin synchronisation
	// ****************************************************************
	logic rst_n;
	logic pin_sync;

	eprd_sync #(.RST_VAL(1'b0)) u_rst_sync (
		.clk_i   (CLK_I),
		.rst_n_i (RST_N_I),
		.d_i     (1'b1),
		.q_o     (rst_n)
	);

	// the pin idles high on its pullup, so reset to that level to avoid a false edge
	eprd_sync #(.RST_VAL(1'b1)) u_pin_sync (
		.clk_i   (CLK_I),
		.rst_n_i (rst_n),
		.d_i     (REQ_PIN_I), // see R13
		.q_o     (pin_sync)
	);

	// ****************************************************************
	// control state
	// ****************************************************************
	logic            pdd;
	logic            edg;
	logic            pe;
	logic            flag;
	logic            ie;
	logic            mode;
	logic            pe_prev;
	logic [ST_W-1:0] stat;
	logic [ST_W-1:0] mask;
	logic            next_pdd;
	logic            next_edg;
	logic            next_pe;
	logic            next_flag;
	logic            next_ie;
	logic            next_mode;
	logic            next_pe_prev;
	logic [ST_W-1:0] next_stat;
	logic [ST_W-1:0] next_mask;
	logic            next_pull;
	logic            next_cpu_req;
	logic            next_int;

	logic pin_asserted;
	logic pin_edge;
	logic level_hold;
	logic pe_rise;
	logic flag_set;
	logic ack_req;

	eprd_detect u_detect (
		.clk_i      (CLK_I),
		.rst_n_i    (rst_n),
		.pin_i      (pin_sync),
		.rising_i   (edg),
		.enable_i   (pe),
		.asserted_o (pin_asserted),
		.edge_o     (pin_edge)
	);

	// ****************************************************************
	// axi4-lite slave state
	// ****************************************************************
	logic              aw_full;
	logic              w_full;
	logic [ADDR_W-1:0] aw_addr;
	logic [7:0]        w_byte;
	logic              w_lane0;
	logic              bvalid;
	logic [1:0]        bresp;
	logic              rvalid;
	logic [1:0]        rresp;
	logic [7:0]        rbyte;
	logic              next_aw_full;
	logic              next_w_full;
	logic [ADDR_W-1:0] next_aw_addr;
	logic [7:0]        next_w_byte;
	logic              next_w_lane0;
	logic              next_bvalid;
	logic [1:0]        next_bresp;
	logic              next_rvalid;
	logic [1:0]        next_rresp;
	logic [7:0]        next_rbyte;
	logic              do_write;
	logic              wr_ctrl;
	logic              wr_stat;
	logic              wr_mask;
	logic [7:0]        ctrl_view;
	logic              rd_hit;

	// ****************************************************************
	// bus next state
	// ****************************************************************
	always_comb begin
		// write address and data are taken in either order, then answered together
		do_write     = aw_full & w_full & ~bvalid;
		next_aw_full = aw_full;
		next_w_full  = w_full;
		next_aw_addr = aw_addr;
		next_w_byte  = w_byte;
		next_w_lane0 = w_lane0;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
			next_aw_full = 1'b1;
			next_aw_addr = S_AXI_AWADDR_I;
		end
		if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
			next_w_full  = 1'b1;
			next_w_byte  = S_AXI_WDATA_I[7:0];
			next_w_lane0 = S_AXI_WSTRB_I[0];
		end
		if (bvalid && S_AXI_BREADY_I) begin
			next_bvalid = 1'b0;
		end
		if (do_write) begin
			next_aw_full = 1'b0;
			next_w_full  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = (wr_ctrl || wr_stat || wr_mask) ? RESP_OKAY : RESP_SLVERR;
		end

		ctrl_view           = CTRL_RST;
		ctrl_view[BIT_PDD]  = pdd;
		ctrl_view[BIT_EDG]  = edg;
		ctrl_view[BIT_PE]   = pe;
		ctrl_view[BIT_FLAG] = flag; // see R6
		ctrl_view[BIT_IE]   = ie;
		ctrl_view[BIT_MOD]  = mode;
		// top bit and acknowledge bit stay zero in the read view, see R1 see R7

		next_rvalid = rvalid;
		next_rresp  = rresp;
		next_rbyte  = rbyte;
		rd_hit      = 1'b0;
		if (rvalid && S_AXI_RREADY_I) begin
			next_rvalid = 1'b0;
		end
		if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
			next_rvalid = 1'b1;
			rd_hit      = 1'b1;
			next_rresp  = RESP_OKAY;
			case (S_AXI_ARADDR_I[7:0])
				CTRL_ADDR: next_rbyte = ctrl_view;
				STAT_ADDR: next_rbyte = {6'h00, stat};
				MASK_ADDR: next_rbyte = {6'h00, mask};
				default: begin
					next_rbyte = 8'h00;
					next_rresp = RESP_SLVERR;
					rd_hit     = 1'b0;
				end
			endcase
			if (ADDR_W > 8 && (S_AXI_ARADDR_I >> 8) != '0) begin
				next_rbyte = 8'h00;
				next_rresp = RESP_SLVERR;
			end
		end
	end

	always_comb begin
		wr_ctrl = 1'b0;
		wr_stat = 1'b0;
		wr_mask = 1'b0;
		if (do_write && ((aw_addr >> 8) == '0)) begin
			wr_ctrl = (aw_addr[7:0] == CTRL_ADDR);
			wr_stat = (aw_addr[7:0] == STAT_ADDR);
			wr_mask = (aw_addr[7:0] == MASK_ADDR);
		end
	end

	// ****************************************************************
	// detection and register next state
	// ****************************************************************
	always_comb begin
		level_hold   = pe & mode & pin_asserted; // see R10
		pe_rise      = pe & ~pe_prev;
		flag_set     = pe & (pin_edge | level_hold | pe_rise); // see R5 see R12
		ack_req      = wr_ctrl & w_lane0 & w_byte[BIT_ACK];

		next_pdd     = pdd;
		next_edg     = edg;
		next_pe      = pe;
		next_ie      = ie;
		next_mode    = mode;
		next_mask    = mask;
		next_pe_prev = pe;
		if (wr_ctrl && w_lane0) begin
			// bit 7 is not stored, see R1
			next_pdd  = w_byte[BIT_PDD];
			next_edg  = w_byte[BIT_EDG];
			next_pe   = w_byte[BIT_PE];
			next_ie   = w_byte[BIT_IE];
			next_mode = w_byte[BIT_MOD];
		end
		if (wr_mask && w_lane0) begin
			next_mask = w_byte[ST_W-1:0];
		end

		// a held level keeps setting, so an acknowledge cannot win, see R8
		next_flag = flag_set | (flag & ~ack_req); // see R7

		next_stat = stat;
		if (wr_stat && w_lane0) begin
			next_stat = stat & ~w_byte[ST_W-1:0];
		end
		// set beats a same-cycle write-one clear
		if (pe && (pin_edge || pe_rise)) begin
			next_stat[ST_EVENT] = 1'b1;
		end
		if (ack_req && level_hold) begin
			next_stat[ST_REFUSED] = 1'b1;
		end

		next_pull    = pe & ~pdd & ~edg; // see R2 see R4
		next_cpu_req = next_ie & next_flag; // see R9
		next_int     = |(next_stat & next_mask);
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			pdd             <= CTRL_RST[BIT_PDD]; // see R13
			edg             <= CTRL_RST[BIT_EDG];
			pe              <= CTRL_RST[BIT_PE];
			flag            <= CTRL_RST[BIT_FLAG];
			ie              <= CTRL_RST[BIT_IE];
			mode            <= CTRL_RST[BIT_MOD];
			pe_prev         <= 1'b0;
			stat            <= STAT_RST;
			mask            <= MASK_RST;
			PULL_EN_O       <= 1'b0;
			CPU_REQ_O       <= 1'b0;
			INT_O           <= 1'b0;
			aw_full         <= 1'b0;
			w_full          <= 1'b0;
			aw_addr         <= '0;
			w_byte          <= 8'h00;
			w_lane0         <= 1'b0;
			bvalid          <= 1'b0;
			bresp           <= RESP_OKAY;
			rvalid          <= 1'b0;
			rresp           <= RESP_OKAY;
			rbyte           <= 8'h00;
			S_AXI_AWREADY_O <= 1'b0;
			S_AXI_WREADY_O  <= 1'b0;
			S_AXI_ARREADY_O <= 1'b0;
		end else begin
			pdd             <= next_pdd;
			edg             <= next_edg;
			pe              <= next_pe;
			flag            <= next_flag;
			ie              <= next_ie;
			mode            <= next_mode;
			pe_prev         <= next_pe_prev;
			stat            <= next_stat;
			mask            <= next_mask;
			PULL_EN_O       <= next_pull;
			CPU_REQ_O       <= next_cpu_req;
			INT_O           <= next_int;
			aw_full         <= next_aw_full;
			w_full          <= next_w_full;
			aw_addr         <= next_aw_addr;
			w_byte          <= next_w_byte;
			w_lane0         <= next_w_lane0;
			bvalid          <= next_bvalid;
			bresp           <= next_bresp;
			rvalid          <= next_rvalid;
			rresp           <= next_rresp;
			rbyte           <= next_rbyte;
			// ready drops as soon as a beat is held, so one write is in flight
			S_AXI_AWREADY_O <= ~next_aw_full & ~next_bvalid;
			S_AXI_WREADY_O  <= ~next_w_full & ~next_bvalid;
			S_AXI_ARREADY_O <= ~next_rvalid & ~(S_AXI_ARVALID_I & S_AXI_ARREADY_O);
		end
	end

	assign S_AXI_BVALID_O = bvalid;
	assign S_AXI_BRESP_O  = bresp;
	assign S_AXI_RVALID_O = rvalid;
	assign S_AXI_RRESP_O  = rresp;
	assign S_AXI_RDATA_O  = {24'h000000, rbyte};

	// ****************************************************************
	// checks
	// ****************************************************************
	a_top_bit_zero: assert property (@(posedge CLK_I) disable iff (!rst_n) // see R1
		(rd_hit && S_AXI_ARADDR_I[7:0] == CTRL_ADDR) |=> !S_AXI_RDATA_O[BIT_RSVD])
		else $error("reserved top bit read back non-zero");

	a_ack_reads_zero: assert property (@(posedge CLK_I) disable iff (!rst_n) // see R7
		(rd_hit && S_AXI_ARADDR_I[7:0] == CTRL_ADDR) |=> !S_AXI_RDATA_O[BIT_ACK])
		else $error("acknowledge bit read back non-zero");

	a_ack_clears_flag: assert property (@(posedge CLK_I) disable iff (!rst_n) // see R7
		(ack_req && !flag_set) |=> !flag)
		else $error("acknowledge did not clear the event flag");

	a_level_holds_flag: assert property (@(posedge CLK_I) disable iff (!rst_n) // see R8
		(pe && mode && pin_asserted) |=> flag)
		else $error("held level did not keep the flag set");

	a_pull_rising_off: assert property (@(posedge CLK_I) disable iff (!rst_n) // see R4
		(pe && edg) |=> !PULL_EN_O)
		else $error("pullup on while rising polarity selected");

	a_pull_default_on: assert property (@(posedge CLK_I) disable iff (!rst_n) // see R2
		(pe && !edg && !pdd) |=> PULL_EN_O)
		else $error("pullup off though enabled and not disabled");

	a_disabled_quiet: assert property (@(posedge CLK_I) disable iff (!rst_n) // see R5
		(!pe && !flag) |=> !flag)
		else $error("event flag set while pin function disabled");

	a_edge_sets_flag: assert property (@(posedge CLK_I) disable iff (!rst_n) // see R11
		(pe && pin_edge) |=> flag ##1 (flag || $past(ack_req)))
		else $error("detected edge did not set the event flag");

	a_enable_sets_flag: assert property (@(posedge CLK_I) disable iff (!rst_n) // see R12
		(pe && !pe_prev) |=> flag)
		else $error("turning on the pin function did not set the flag");

	a_request_follows: assert property (@(posedge CLK_I) disable iff (!rst_n) // see R9
		##1 (CPU_REQ_O == (flag && ie)))
		else $error("cpu request does not follow flag and enable");

	a_edge_only_clear: assert property (@(posedge CLK_I) disable iff (!rst_n) // see R10
		(!mode && ack_req && !pin_edge && !pe_rise) |=> !flag)
		else $error("edge-only mode flag not cleared by acknowledge");

endmodule

// [test/eprd_src.sv]
// model of the outside source driving the request pin
module eprd_src (
	// clock and pull device
	input  wire logic clk_i,
	input  wire logic pull_en_i,
	// request pin
	output logic      pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic driving = 1'h1;
	logic level   = 1'h1;
	// a released pin with the pullup off is shown at the inverse of the last driven level
	assign pin_o = driving ? level : (pull_en_i ? 1'h1 : ~level);
	task automatic drive(input logic v);
		@(posedge clk_i);
		driving <= 1'h1;
		level   <= v;
	endtask
	task automatic release_pin();
		@(posedge clk_i);
		driving <= 1'h0;
	endtask
endmodule

// [test/eprd_top_tb.sv]
// self-checking bench of the pin request detector
module eprd_top_tb import eprd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'h0;
	logic        rst_n;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic        pin, pull_en, cpu_req, irq;
	int          mismatches = 0;
	int          tests_run = 0;

	always #25 clk = ~clk;

	eprd_top uut (.CLK_I(clk), .RST_N_I(rst_n),
		.S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
		.S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
		.S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
		.S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
		.S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
		.S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .REQ_PIN_I(pin),
		.PULL_EN_O(pull_en), .CPU_REQ_O(cpu_req), .INT_O(irq));

	eprd_src src (.clk_i(clk), .pull_en_i(pull_en), .pin_o(pin));

	// ****************************************************************
	// compare and bus tasks
	// ****************************************************************
	task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected word at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic cmp_bit(input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected level at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	// signals are sampled at the edge itself, so registered outputs show pre-edge values
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY,
		input logic [3:0] s = 4'hF);
		logic [1:0] r = 2'h1;
		@(posedge clk);
		awaddr  <= a;
		awvalid <= 1'h1;
		wdata   <= {24'h000000, d};
		wstrb   <= s;
		wvalid  <= 1'h1;
		bready  <= 1'h1;
		do begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'h0;
			if (wready)
				wvalid <= 1'h0;
		end while (!bvalid);
		r = bresp;
		bready <= 1'h0;
		cmp_word({30'h0, er}, {30'h0, r});
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
		logic [31:0] d = 32'hDEADBEEF;
		logic [1:0]  r = 2'h1;
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'h1;
		rready  <= 1'h1;
		do begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'h0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
		cmp_word({24'h0, e}, d);
		cmp_word({30'h0, er}, {30'h0, r});
	endtask
	// the pin path is two sync flops, a detector and the flag: six edges covers it
	task automatic settle();
		repeat (6) @(posedge clk);
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		final_report();
	end

	initial begin
		rst_n   <= 1'h0;
		awaddr  <= 8'h00;
		awvalid <= 1'h0;
		wdata   <= 32'h0;
		wstrb   <= 4'h0;
		wvalid  <= 1'h0;
		bready  <= 1'h0;
		araddr  <= 8'h00;
		arvalid <= 1'h0;
		rready  <= 1'h0;
		repeat (5) @(posedge clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge clk);
		rd(CTRL_ADDR, 8'h00);
		rd(STAT_ADDR, 8'h00);
		rd(MASK_ADDR, 8'h00);
		cmp_bit(1'h0, pull_en);
		cmp_bit(1'h0, cpu_req);
		cmp_bit(1'h0, irq);
		$display("test reset done");
		wr(CTRL_ADDR, 8'h84);
		rd(CTRL_ADDR, 8'h00);
		wr(CTRL_ADDR, 8'h08);
		rd(CTRL_ADDR, 8'h00);
		src.drive(1'h0);
		settle();
		src.drive(1'h1);
		settle();
		rd(CTRL_ADDR, 8'h00);
		$display("test reserved done");
		wr(CTRL_ADDR, 8'h10);
		settle();
		rd(CTRL_ADDR, 8'h18);
		cmp_bit(1'h1, pull_en);
		wr(CTRL_ADDR, 8'h10);
		rd(CTRL_ADDR, 8'h18);
		wr(CTRL_ADDR, 8'h14);
		rd(CTRL_ADDR, 8'h10);
		wr(CTRL_ADDR, 8'h50);
		settle();
		cmp_bit(1'h0, pull_en);
		wr(CTRL_ADDR, 8'h10);
		$display("test enable done");
		src.drive(1'h0);
		settle();
		rd(CTRL_ADDR, 8'h18);
		wr(CTRL_ADDR, 8'h14);
		rd(CTRL_ADDR, 8'h10);
		src.drive(1'h1);
		settle();
		rd(CTRL_ADDR, 8'h10);
		$display("test falling done");
		wr(CTRL_ADDR, 8'h12);
		settle();
		cmp_bit(1'h0, cpu_req);
		src.drive(1'h0);
		settle();
		cmp_bit(1'h1, cpu_req);
		wr(CTRL_ADDR, 8'h10);
		settle();
		cmp_bit(1'h0, cpu_req);
		wr(CTRL_ADDR, 8'h14);
		src.drive(1'h1);
		settle();
		$display("test interrupt enable done");
		wr(CTRL_ADDR, 8'h11);
		src.drive(1'h0);
		settle();
		rd(CTRL_ADDR, 8'h19);
		wr(CTRL_ADDR, 8'h15);
		rd(CTRL_ADDR, 8'h19);
		src.drive(1'h1);
		settle();
		wr(CTRL_ADDR, 8'h15);
		rd(CTRL_ADDR, 8'h11);
		$display("test level done");
		wr(CTRL_ADDR, 8'h30);
		settle();
		wr(CTRL_ADDR, 8'h34);
		src.drive(1'h0);
		settle();
		rd(CTRL_ADDR, 8'h30);
		cmp_bit(1'h0, pull_en);
		src.drive(1'h1);
		settle();
		rd(CTRL_ADDR, 8'h38);
		wr(CTRL_ADDR, 8'h04);
		src.release_pin();
		settle();
		rd(CTRL_ADDR, 8'h00);
		cmp_bit(1'h0, pull_en);
		src.drive(1'h1);
		$display("test rising done");
		rd(STAT_ADDR, 8'h03);
		wr(STAT_ADDR, 8'h03);
		rd(STAT_ADDR, 8'h00);
		wr(CTRL_ADDR, 8'h10);
		settle();
		rd(STAT_ADDR, 8'h01);
		cmp_bit(1'h0, irq);
		wr(MASK_ADDR, 8'h01);
		settle();
		cmp_bit(1'h1, irq);
		rd(MASK_ADDR, 8'h01);
		wr(STAT_ADDR, 8'h01);
		settle();
		cmp_bit(1'h0, irq);
		rd(STAT_ADDR, 8'h00);
		$display("test status done");
		rd(8'h00, 8'h00, RESP_SLVERR);
		wr(8'h00, 8'h10, RESP_SLVERR);
		rd(CTRL_ADDR, 8'h18);
		// byte lane 0 off: the acknowledge must not land
		wr(CTRL_ADDR, 8'h04, RESP_OKAY, 4'h0);
		rd(CTRL_ADDR, 8'h18);
		$display("test unmapped done");
		rst_n <= 1'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge clk);
		rd(CTRL_ADDR, 8'h00);
		rd(MASK_ADDR, 8'h00);
		cmp_bit(1'h0, cpu_req);
		cmp_bit(1'h0, pull_en);
		$display("test mid-run reset done");
		final_report();
	end
endmodule
